// file: hdl/uart_dma_pkg.sv
// Package: register map, field layout, constants and carriers of the UART buffer DMA engine
package uart_dma_pkg;

  // Register word offsets inside the engine block (low address byte)
  localparam logic [7:0] OFS_TX_ADDR     = 8'h00;
  localparam logic [7:0] OFS_TX_LEN      = 8'h01;
  localparam logic [7:0] OFS_TX_CTRL     = 8'h02;
  localparam logic [7:0] OFS_TX_STAT_LO  = 8'h03;
  localparam logic [7:0] OFS_TX_STAT_HI  = 8'h04;
  localparam logic [7:0] OFS_RX_ADDR     = 8'h05;
  localparam logic [7:0] OFS_RX_LEN      = 8'h06;
  localparam logic [7:0] OFS_RX_CTRL     = 8'h07;
  localparam logic [7:0] OFS_RX_STAT_LO  = 8'h08;
  localparam logic [7:0] OFS_RX_STAT_HI  = 8'h09;
  localparam logic [7:0] OFS_SEG_CFG     = 8'h0a;
  localparam logic [7:0] OFS_BASE        = 8'h0b;
  // UART window: offsets 0x20..0x2f forwarded to the UART core
  localparam logic [7:0] OFS_UART_LO     = 8'h20;
  localparam logic [7:0] OFS_UART_HI     = 8'h2f;

  // UART core register offsets used by the engine
  localparam logic [3:0] UART_CSR        = 4'h4;
  localparam logic [3:0] UART_RHR        = 4'h8;
  localparam logic [3:0] UART_THR        = 4'hc;

  // UART status bit positions
  localparam int CSR_UART_RX_READY_BIT   = 0;
  localparam int CSR_UART_TX_READY_BIT   = 1;
  localparam int CSR_OVRE_BIT    = 5;
  localparam int CSR_FRAME_BIT   = 6;
  localparam int CSR_PARE_BIT    = 7;
  localparam int CSR_TIMEOUT_BIT = 8;

  // Control register bits
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;

  // Status high fields
  localparam int STH_BUSY_BIT = 7;
  localparam int STH_DONE_BIT = 6;

  // Reset values
  localparam logic [2:0] SEG_CFG_RESET   = 3'h0;
  localparam logic [7:0] BASE_RESET      = 8'h20;

  typedef enum { CAUSE_NONE, CAUSE_DONE, CAUSE_TIMEOUT, CAUSE_ABORT } cause_e;

  typedef struct packed {
    logic [2:0] errs;  // parity, framing, overrun
    logic [1:0] cause;
    logic       done;
    logic       busy;
  } chan_stat_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [3:0]  addr;
    logic [7:0]  wdata;
  } uart_req_s;

endpackage

// file: hdl/uart_dma_engine.sv
// UART to shared buffer RAM block-transfer engine with register slave and UART arbiter
//
// Contract
// - Once programmed the engine moves bytes between buffer and UART alone.
// - Interrupt raised when the programmed byte count has been moved.
// - UART errors during a receive block are recorded in receive channel status.
// - Processor UART accesses pass through the engine; other memories never stall.
// - Buffer address wraps to start of its segment at segment end.
// - Separate configuration and status registers for transmit and receive.
// - Transmit paced by UART transmit ready, receive by receive ready.
// - Each byte step reads UART status, then accesses the data register.
// - Transmit and receive channels run concurrently.
// - Receive ends on completion, timeout or abort, each raising receive done.
// - Receive status pair reports byte count, errors and termination cause.
// - Transmit ends on completion or abort, each raising transmit done.
// - Transmit status pair reports byte count and termination cause.
// - Buffer divided into segments per firmware segment configuration register.
// - Engine derives segment start and end from configured segment count.
// - After reset the buffer is one unsegmented region.
// - Engine and UART blocks decode at any 256-byte aligned base.
// - Engine arbitrates its own and processor accesses to the UART.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module uart_dma_engine
  import uart_dma_pkg::*;
#(
  parameter int AW = 11,
  parameter int LW = 11
) (
  // Clock and reset
  input  wire  logic          mclk,
  input  wire  logic          sys_rst,
  // Processor register port
  input  wire  logic [15:0]   cpu_addr,
  input  wire  logic [7:0]    cpu_wdata,
  input  wire  logic          cpu_wr,
  input  wire  logic          cpu_rd,
  output logic       [7:0]    cpu_rdata,
  // UART core register port
  output uart_req_s           uart_req,
  input  wire  logic [15:0]   uart_rdata,
  input  wire  logic          uart_tx_ready,
  input  wire  logic          uart_rx_ready,
  // Shared buffer RAM port, read data one cycle after request
  output logic                ram_rd,
  output logic                ram_wr,
  output logic       [AW-1:0] ram_addr,
  output logic       [7:0]    ram_wdata,
  input  wire  logic [7:0]    ram_rdata,
  // Termination interrupts, one-cycle pulses
  output logic                tx_block_done_irq,
  output logic                rx_block_done_irq
);

  typedef enum { S_IDLE, S_STAT, S_STAT_W, S_RAM, S_DATA, S_DATA_W } step_e;

  // Address decode: top byte matches relocatable base
  logic [7:0] base_q, base_d;
  logic [7:0] ofs;
  logic       hit, uart_hit;
  assign ofs      = cpu_addr[7:0];
  assign hit      = cpu_addr[15:8] == base_q;
  assign uart_hit = hit && ofs >= OFS_UART_LO && ofs <= OFS_UART_HI;

  // Segment configuration: 2^n segments
  logic [2:0] seg_q, seg_d;

  // Per-channel state, index 0 transmit, 1 receive
  step_e           st_q   [2], st_d   [2];
  logic [AW-1:0]   addr_q [2], addr_d [2];
  logic [AW-1:0]   start_q[2], start_d[2];
  logic [LW-1:0]   len_q  [2], len_d  [2];
  logic [LW-1:0]   cnt_q  [2], cnt_d  [2];
  chan_stat_s      stat_q [2], stat_d [2];
  logic [7:0]      byte_q [2], byte_d [2];
  logic            irq_q  [2], irq_d  [2];
  logic            want   [2];
  logic            grant  [2];
  logic            cpu_own;
  logic            pend_q, pend_d;
  // Tx RAM byte stands only in the cycle after the read
  logic            fresh_q, fresh_d;
  logic [7:0]      rdata_q, rdata_d;
  logic            uart_sel_q;

  // Segment mask: the upper address bits pick the segment
  logic [AW-1:0] seg_mask;
  always_comb begin
    seg_mask = '1;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(seg_q) && i < AW) begin
        seg_mask[AW-1-i] = 1'b0;
      end
    end
  end

  // Processor has priority at the UART; engine steps wait a cycle
  assign cpu_own  = uart_hit && (cpu_wr || cpu_rd);
  assign grant[0] = want[0] && !cpu_own;
  assign grant[1] = want[1] && !cpu_own && !want[0];

  always_comb begin
    uart_req = '0;
    if (cpu_own) begin
      uart_req.rd    = cpu_rd;
      uart_req.wr    = cpu_wr;
      uart_req.addr  = ofs[3:0];
      uart_req.wdata = cpu_wdata;
    end else if (grant[0]) begin
      uart_req.rd    = st_q[0] == S_STAT;
      uart_req.wr    = st_q[0] == S_DATA;
      uart_req.addr  = (st_q[0] == S_STAT) ? UART_CSR : UART_THR;
      uart_req.wdata = fresh_q ? ram_rdata : byte_q[0];
    end else if (grant[1]) begin
      uart_req.rd    = 1'b1;
      uart_req.addr  = (st_q[1] == S_STAT) ? UART_CSR : UART_RHR;
    end
  end

  // RAM: transmit reads in S_RAM, receive writes in S_RAM; receive wins a clash
  always_comb begin
    ram_rd    = 1'b0;
    ram_wr    = 1'b0;
    ram_addr  = addr_q[0];
    // Rx holds S_RAM one cycle only, so the UART data still stands
    ram_wdata = uart_rdata[7:0];
    if (st_q[1] == S_RAM) begin
      ram_wr   = 1'b1;
      ram_addr = addr_q[1];
    end else if (st_q[0] == S_RAM) begin
      ram_rd   = 1'b1;
    end
  end

  // Channel sequencers, one per direction
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      localparam logic [7:0] O_ADDR = (c == 0) ? OFS_TX_ADDR : OFS_RX_ADDR;
      localparam logic [7:0] O_LEN  = (c == 0) ? OFS_TX_LEN  : OFS_RX_LEN;
      localparam logic [7:0] O_CTRL = (c == 0) ? OFS_TX_CTRL : OFS_RX_CTRL;
      logic wr_ok, ram_ok, rdy;
      assign wr_ok  = hit && cpu_wr && !stat_q[c].busy;
      assign ram_ok = (c == 1) || st_q[1] != S_RAM;
      assign rdy    = (c == 0) ? uart_rdata[CSR_UART_TX_READY_BIT]
                               : uart_rdata[CSR_UART_RX_READY_BIT];
      assign want[c] = st_q[c] == S_STAT || st_q[c] == S_DATA;

      always_comb begin
        st_d[c]    = st_q[c];
        addr_d[c]  = addr_q[c];
        start_d[c] = start_q[c];
        len_d[c]   = len_q[c];
        cnt_d[c]   = cnt_q[c];
        stat_d[c]  = stat_q[c];
        byte_d[c]  = byte_q[c];
        irq_d[c]   = 1'b0;
        // Only address and length are needed before starting
        if (wr_ok && ofs == O_ADDR) begin
          addr_d[c]  = {{(AW > 8 ? AW-8 : 0){1'b0}}, cpu_wdata} << 3;
          start_d[c] = addr_d[c];
        end
        if (wr_ok && ofs == O_LEN) begin
          len_d[c] = {{(LW > 8 ? LW-8 : 0){1'b0}}, cpu_wdata} << 3;
        end
        case (st_q[c])
          S_IDLE: begin
            if (wr_ok && ofs == O_CTRL && cpu_wdata[CTRL_START_BIT]) begin
              st_d[c]     = (len_q[c] == '0) ? S_IDLE : S_STAT;
              cnt_d[c]    = '0;
              stat_d[c]   = '0;
              stat_d[c].busy = len_q[c] != '0;
              irq_d[c]    = len_q[c] == '0;
              stat_d[c].done = len_q[c] == '0;
              stat_d[c].cause = len_q[c] == '0 ? 2'(CAUSE_DONE) : 2'(CAUSE_NONE);
            end
          end
          S_STAT:   if (grant[c]) st_d[c] = S_STAT_W;
          S_STAT_W: begin
            if (c == 1) begin
              stat_d[c].errs = stat_q[c].errs | {uart_rdata[CSR_PARE_BIT],
                               uart_rdata[CSR_FRAME_BIT], uart_rdata[CSR_OVRE_BIT]};
            end
            if (c == 1 && uart_rdata[CSR_TIMEOUT_BIT] && !rdy) begin
              st_d[c]         = S_IDLE;
              stat_d[c].busy  = 1'b0;
              stat_d[c].done  = 1'b1;
              stat_d[c].cause = 2'(CAUSE_TIMEOUT);
              irq_d[c]        = 1'b1;
            end else if (rdy) begin
              st_d[c] = (c == 0) ? S_RAM : S_DATA;
            end else begin
              st_d[c] = S_STAT;
            end
          end
          S_RAM: begin
            if (ram_ok) begin
              st_d[c] = (c == 0) ? S_DATA : S_DATA_W;
            end
          end
          S_DATA: if (grant[c]) st_d[c] = (c == 0) ? S_DATA_W : S_RAM;
          S_DATA_W: begin
            cnt_d[c] = cnt_q[c] + 1'b1;
            // Wrap inside the segment, keep the segment bits
            addr_d[c] = (start_q[c] & ~seg_mask) |
                        ((addr_q[c] + 1'b1) & seg_mask);
            if (cnt_q[c] + 1'b1 == len_q[c]) begin
              st_d[c]         = S_IDLE;
              stat_d[c].busy  = 1'b0;
              stat_d[c].done  = 1'b1;
              stat_d[c].cause = 2'(CAUSE_DONE);
              irq_d[c]        = 1'b1;
            end else begin
              st_d[c] = S_STAT;
            end
          end
          default: st_d[c] = S_IDLE;
        endcase
        // Capture byte: tx from RAM read data, rx from UART read data
        if (c == 0 && fresh_q) byte_d[c] = ram_rdata;
        if (c == 1 && st_q[c] == S_RAM) byte_d[c] = uart_rdata[7:0];
        // Abort wins over any step in progress
        if (hit && cpu_wr && ofs == O_CTRL && cpu_wdata[CTRL_ABORT_BIT]
            && stat_q[c].busy) begin
          st_d[c]         = S_IDLE;
          stat_d[c].busy  = 1'b0;
          stat_d[c].done  = 1'b1;
          stat_d[c].cause = 2'(CAUSE_ABORT);
          irq_d[c]        = 1'b1;
        end
      end

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          st_q[c]    <= S_IDLE;
          addr_q[c]  <= '0;
          start_q[c] <= '0;
          len_q[c]   <= '0;
          cnt_q[c]   <= '0;
          stat_q[c]  <= '0;
          byte_q[c]  <= '0;
          irq_q[c]   <= 1'b0;
        end else begin
          st_q[c]    <= st_d[c];
          addr_q[c]  <= addr_d[c];
          start_q[c] <= start_d[c];
          len_q[c]   <= len_d[c];
          cnt_q[c]   <= cnt_d[c];
          stat_q[c]  <= stat_d[c];
          irq_q[c]   <= irq_d[c];
          byte_q[c]  <= byte_d[c];
        end
      end
    end
  endgenerate

  assign tx_block_done_irq = irq_q[0];
  assign rx_block_done_irq = irq_q[1];

  // Register file and read-back
  always_comb begin
    seg_d   = seg_q;
    base_d  = base_q;
    pend_d  = 1'b0;
    rdata_d = 8'h00;
    fresh_d = st_q[0] == S_RAM && st_q[1] != S_RAM;
    if (hit && cpu_wr && ofs == OFS_SEG_CFG) seg_d = cpu_wdata[2:0];
    if (hit && cpu_wr && ofs == OFS_BASE) base_d = cpu_wdata;
    if (hit && cpu_rd && !uart_hit) begin
      case (ofs)
        OFS_TX_ADDR:    rdata_d = addr_q[0][AW-1:3];
        OFS_TX_LEN:     rdata_d = len_q[0][LW-1:3];
        OFS_TX_STAT_LO: rdata_d = cnt_q[0][7:0];
        OFS_TX_STAT_HI: rdata_d = {stat_q[0].busy, stat_q[0].done, 1'b0,
                                   stat_q[0].cause, cnt_q[0][LW-1:8]};
        OFS_RX_ADDR:    rdata_d = addr_q[1][AW-1:3];
        OFS_RX_LEN:     rdata_d = len_q[1][LW-1:3];
        OFS_RX_STAT_LO: rdata_d = cnt_q[1][7:0];
        OFS_RX_STAT_HI: rdata_d = {stat_q[1].busy, stat_q[1].done,
                                   stat_q[1].errs[0] | stat_q[1].errs[1] | stat_q[1].errs[2],
                                   stat_q[1].cause, cnt_q[1][LW-1:8]};
        OFS_SEG_CFG:    rdata_d = {5'h00, seg_q};
        OFS_BASE:       rdata_d = base_q;
        default:        rdata_d = 8'h00;
      endcase
    end
    pend_d = cpu_rd && uart_hit;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      seg_q      <= SEG_CFG_RESET;
      base_q     <= BASE_RESET;
      pend_q     <= 1'b0;
      rdata_q    <= 8'h00;
      uart_sel_q <= 1'b0;
      fresh_q    <= 1'b0;
    end else begin
      fresh_q    <= fresh_d;
      seg_q      <= seg_d;
      base_q     <= base_d;
      pend_q     <= pend_d;
      rdata_q    <= rdata_d;
      uart_sel_q <= pend_d;
    end
  end

  // UART read data returns a cycle after the forwarded read
  assign cpu_rdata = uart_sel_q ? uart_rdata[7:0] : rdata_q;

endmodule
`default_nettype wire

// file: verif/uart_dma_props.sv
// Port checker for the UART buffer DMA engine
`timescale 1ns/1ns
`default_nettype none
module uart_dma_props
  import uart_dma_pkg::*;
#(
  parameter int AW = 11,
  parameter int LW = 11
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // Processor and UART ports
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0]  cpu_wdata,
  input wire logic        cpu_wr,
  input wire logic        cpu_rd,
  input wire logic [7:0]  cpu_rdata,
  input wire uart_req_s   uart_req,
  input wire logic [15:0] uart_rdata,
  // RAM strobes and interrupts
  input wire logic        ram_rd,
  input wire logic        ram_wr,
  input wire logic        tx_block_done_irq,
  input wire logic        rx_block_done_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic       hit_uart;
  logic       csr_rd;
  logic       eng_wr;
  logic       eng_rd;
  logic [3:0] since_q;
  logic [3:0] since_d;
  assign hit_uart = cpu_addr[15:8] == BASE_RESET && cpu_addr[7:4] == OFS_UART_LO[7:4];
  assign csr_rd = uart_req.rd && uart_req.addr == UART_CSR;
  assign eng_wr = uart_req.wr && uart_req.addr == UART_THR && !cpu_wr;
  assign eng_rd = uart_req.rd && uart_req.addr == UART_RHR && !cpu_rd;
  // Cycles since last status read, saturating so a missing read shows up
  always_comb begin
    since_d = since_q;
    if (csr_rd) since_d = 4'h0;
    else if (since_q != 4'hf) since_d = since_q + 4'h1;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) since_q <= 4'hf;
    else since_q <= since_d;
  end
  a_tx_irq_pulse: assert property (tx_block_done_irq |=> !tx_block_done_irq)
    else $error("tx done pulse too long");
  a_rx_irq_pulse: assert property (rx_block_done_irq |=> !rx_block_done_irq)
    else $error("rx done pulse too long");
  a_cpu_uart_wr: assert property (cpu_wr && hit_uart |-> uart_req.wr &&
    uart_req.addr == cpu_addr[3:0] && uart_req.wdata == cpu_wdata)
    else $error("processor UART write not forwarded");
  a_cpu_uart_rd: assert property (cpu_rd && hit_uart |-> uart_req.rd
    ##1 cpu_rdata == uart_rdata[7:0]) else $error("processor UART read not forwarded");
  a_unmapped_zero: assert property (cpu_rd && cpu_addr[15:8] == BASE_RESET &&
    cpu_addr[7:0] inside {[8'h0c:8'h1f]} |=> cpu_rdata == 8'h00)
    else $error("unmapped offset not zero");
  a_thr_after_csr: assert property (eng_wr |-> since_q <= 4'hc)
    else $error("data write without status read");
  a_rhr_after_csr: assert property (eng_rd |-> since_q <= 4'hc)
    else $error("data read without status read");
  a_ram_one_op: assert property (!(ram_rd && ram_wr))
    else $error("RAM read and write together");
  a_uart_one_op: assert property (!(uart_req.rd && uart_req.wr))
    else $error("UART read and write together");
  c_tx_done: cover property (tx_block_done_irq);
  c_rx_done: cover property (rx_block_done_irq);
  c_eng_rx: cover property (eng_rd ##1 ram_wr);
endmodule
`default_nettype wire

// file: verif/uart_ram_model.sv
// UART core and shared buffer RAM model facing the engine
`timescale 1ns/1ns
`default_nettype none
module uart_ram_model
  import uart_dma_pkg::*;
(
  // Clock
  input  wire logic        mclk,
  // UART side
  input  wire uart_req_s   uart_req,
  output logic      [15:0] uart_rdata,
  output logic             uart_tx_ready,
  output logic             uart_rx_ready,
  // RAM side
  input  wire logic        ram_rd,
  input  wire logic        ram_wr,
  input  wire logic [10:0] ram_addr,
  input  wire logic [7:0]  ram_wdata,
  output logic      [7:0]  ram_rdata,
  // Bench controls
  input  wire logic        tx_ok,
  input  wire logic        tmo_en,
  input  wire logic [2:0]  errs,
  input  wire logic [7:0]  rx_avail
);
  logic [7:0]  mem [2048];
  logic [7:0]  tx_log [256];
  logic [7:0]  tx_cnt = 8'h00;
  logic [7:0]  rx_cnt = 8'h00;
  logic [15:0] csr;
  assign uart_tx_ready = tx_ok;
  assign uart_rx_ready = rx_cnt != rx_avail;
  // Timeout only once the line has run dry
  assign csr = {7'h00, tmo_en && !uart_rx_ready, errs, 3'h0, tx_ok, uart_rx_ready};
  initial begin
    uart_rdata = 16'h0000;
    ram_rdata = 8'h00;
  end
  // Idle buses flip so stale data never looks valid
  always @(posedge mclk) begin
    uart_rdata <= ~uart_rdata;
    ram_rdata <= ~ram_rdata;
    if (uart_req.rd) uart_rdata <= uart_req.addr == UART_RHR ? {8'h00, rx_cnt} : csr;
    if (uart_req.rd && uart_req.addr == UART_RHR) rx_cnt <= rx_cnt + 8'h01;
    if (uart_req.wr && uart_req.addr == UART_THR) begin
      tx_log[tx_cnt] <= uart_req.wdata;
      tx_cnt <= tx_cnt + 8'h01;
    end
    if (ram_rd) ram_rdata <= mem[ram_addr];
    if (ram_wr) mem[ram_addr] <= ram_wdata;
  end
endmodule
`default_nettype wire

// file: verif/uart_dma_engine_tb.sv
// Self-checking bench for the UART buffer DMA engine
`timescale 1ns/1ns
`default_nettype none
module uart_dma_engine_tb
  import uart_dma_pkg::*;
;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] cpu_addr = 16'h2000;
  logic [7:0]  cpu_wdata = 8'h00;
  logic        cpu_wr = 1'b0;
  logic        cpu_rd = 1'b0;
  logic [7:0]  cpu_rdata, ram_wdata, ram_rdata, v;
  uart_req_s   uart_req;
  logic [15:0] uart_rdata;
  logic        uart_tx_ready, uart_rx_ready, ram_rd, ram_wr, tx_irq, rx_irq;
  logic [10:0] ram_addr;
  logic [7:0]  rx_avail = 8'h00;
  logic        tx_ok = 1'b1;
  logic        tmo_en = 1'b0;
  logic [2:0]  errs = 3'h0;
  int          mismatches = 0;
  int          total_checks = 0;
  int          n_tx = 0;
  int          n_rx = 0;
  always #5 mclk = ~mclk;
  uart_dma_engine DUT (.mclk(mclk), .sys_rst(sys_rst), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
    .uart_req(uart_req), .uart_rdata(uart_rdata), .uart_tx_ready(uart_tx_ready),
    .uart_rx_ready(uart_rx_ready), .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .tx_block_done_irq(tx_irq),
    .rx_block_done_irq(rx_irq));
  uart_ram_model u_model (.mclk(mclk), .uart_req(uart_req), .uart_rdata(uart_rdata),
    .uart_tx_ready(uart_tx_ready), .uart_rx_ready(uart_rx_ready), .ram_rd(ram_rd),
    .ram_wr(ram_wr), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
    .tx_ok(tx_ok), .tmo_en(tmo_en), .errs(errs), .rx_avail(rx_avail));
  always @(posedge mclk) begin
    if (tx_irq === 1'b1) n_tx <= n_tx + 1;
    if (rx_irq === 1'b1) n_rx <= n_rx + 1;
  end
  task automatic complete_run();
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    @(posedge mclk);
    cpu_addr <= {BASE_RESET, ofs};
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge mclk);
    cpu_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp);
    @(posedge mclk);
    cpu_addr <= {BASE_RESET, ofs};
    cpu_rd <= 1'b1;
    @(posedge mclk);
    cpu_rd <= 1'b0;
    #1 chk(cpu_rdata, exp);
  endtask
  // Interrupt counts rather than levels, so overlapping ends are not missed
  task automatic wait_irq(input int tx_exp, input int rx_exp);
    for (int i = 0; i < 3000 && (n_tx != tx_exp || n_rx != rx_exp); i++) @(negedge mclk);
    chk(8'(n_tx), 8'(tx_exp));
    chk(8'(n_rx), 8'(rx_exp));
  endtask
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
  initial begin
    for (int i = 0; i < 2048; i++) u_model.mem[i] = 8'(i * 7 + 3);
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rchk(OFS_TX_STAT_HI, 8'h00);
    rchk(OFS_RX_STAT_HI, 8'h00);
    rchk(OFS_SEG_CFG, 8'h00);
    rchk(8'h0c, 8'h00);
    rchk(8'h24, 8'h02);
    wr(8'h21, 8'h5a);
    wr(OFS_TX_ADDR, 8'h01);
    wr(OFS_TX_LEN, 8'h02);
    wr(OFS_TX_CTRL, 8'h01);
    wait_irq(1, 0);
    rchk(OFS_TX_STAT_LO, 8'h10);
    rchk(OFS_TX_STAT_HI, 8'h48);
    for (int i = 0; i < 16; i++) chk(u_model.tx_log[i], u_model.mem[8 + i]);
    wr(OFS_SEG_CFG, 8'h01);
    rchk(OFS_SEG_CFG, 8'h01);
    wr(OFS_TX_ADDR, 8'h7f);
    wr(OFS_TX_CTRL, 8'h01);
    wait_irq(2, 0);
    for (int i = 0; i < 16; i++)
      chk(u_model.tx_log[16 + i], u_model.mem[i < 8 ? 1016 + i : i - 8]);
    rx_avail <= 8'd24;
    errs <= 3'h4;
    wr(OFS_RX_ADDR, 8'h08);
    wr(OFS_RX_LEN, 8'h03);
    wr(OFS_TX_ADDR, 8'h02);
    wr(OFS_TX_LEN, 8'h01);
    wr(OFS_RX_CTRL, 8'h01);
    wr(OFS_TX_CTRL, 8'h01);
    wait_irq(3, 1);
    rchk(OFS_RX_STAT_LO, 8'h18);
    rchk(OFS_RX_STAT_HI, 8'h68);
    for (int i = 0; i < 24; i++) chk(u_model.mem[64 + i], 8'(i));
    for (int i = 0; i < 8; i++) chk(u_model.tx_log[32 + i], u_model.mem[16 + i]);
    errs <= 3'h0;
    tmo_en <= 1'b1;
    rx_avail <= 8'd29;
    wr(OFS_RX_CTRL, 8'h01);
    wait_irq(3, 2);
    rchk(OFS_RX_STAT_LO, 8'h05);
    rchk(OFS_RX_STAT_HI, 8'h50);
    tmo_en <= 1'b0;
    tx_ok <= 1'b0;
    wr(OFS_TX_CTRL, 8'h01);
    repeat (40) @(posedge mclk);
    chk(u_model.tx_cnt, 8'd40);
    rchk(OFS_TX_STAT_HI, 8'h80);
    wr(OFS_TX_CTRL, 8'h02);
    wait_irq(4, 2);
    rchk(OFS_TX_STAT_LO, 8'h00);
    rchk(OFS_TX_STAT_HI, 8'h58);
    wr(OFS_RX_CTRL, 8'h01);
    repeat (20) @(posedge mclk);
    wr(OFS_RX_CTRL, 8'h02);
    wait_irq(4, 3);
    rchk(OFS_RX_STAT_LO, 8'h00);
    rchk(OFS_RX_STAT_HI, 8'h58);
    complete_run();
  end
endmodule
bind uart_dma_engine uart_dma_props #(.AW(AW), .LW(LW)) u_props (.mclk(mclk),
  .sys_rst(sys_rst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
  .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .uart_req(uart_req), .uart_rdata(uart_rdata),
  .ram_rd(ram_rd), .ram_wr(ram_wr), .tx_block_done_irq(tx_block_done_irq),
  .rx_block_done_irq(rx_block_done_irq));
`default_nettype wire
